// >>> core/mode_regs_consts.svh
// Constants for the mode register two and three logic of the DRAM device.
// Assumes it is included by bare name from files under core/.
`ifndef MODE_REGS_CONSTS_SVH
`define MODE_REGS_CONSTS_SVH

`define MR_WIDTH            18
`define MR2_RESET           18'h00000
`define MR3_RESET           18'h00000
`define MR2_CWL_MSB         5
`define MR2_CWL_LSB         3
`define MR2_AUTO_SR_BIT     6
`define MR2_FORCED_SR_BIT   7
`define MR2_WRTERM_MSB      10
`define MR2_WRTERM_LSB      9
`define MR3_CAL_EN_BIT      2
`define MR3_CAL_SEL_MSB     1
`define MR3_CAL_SEL_LSB     0
`define BA_MODE_TWO         3'h2
`define BA_MODE_THREE       3'h3
`define CAL_SEL_PATTERN     2'h0
`define CAL_PATTERN         8'hAA
`define BURST_FULL_BEATS    4'h8
`define BURST_CHOP_BEATS    4'h4
`define NIBBLE_OFFSET       3'h4
`define LAT_W               5
`define CWL_TABLE_DEFAULT   32'hCBA98765
`define ADDR_AUTOPRE_BIT    10
`define ADDR_BURST_LEN_BIT  12
`define ADDR_NIBBLE_BIT     2

`endif

// >>> core/mode_regs_pkg.sv
// Types shared by the mode register logic and its burst sequencer.
// Assumes mode_regs_consts.svh sits beside it.
`include "mode_regs_consts.svh"

package mode_regs_pkg;

  typedef enum logic [1:0] {
    TERM_OFF     = 2'h0,
    TERM_NOMINAL = 2'h1,
    TERM_WRITE   = 2'h2
  } term_mode_t;

  typedef enum logic [1:0] {
    SEQ_IDLE  = 2'h0,
    SEQ_WAIT  = 2'h1,
    SEQ_BURST = 2'h2
  } seq_state_t;

  typedef struct packed {
    seq_state_t              state;
    logic [`LAT_W-1:0]       cnt;
    logic [3:0]              beat;
    logic [3:0]              last;
  } seq_regs_t;

  typedef struct packed {
    logic                    ck_s1;
    logic                    ck_s2;
    logic                    ck_s3;
    logic [3:0]              cmd_s1;
    logic [3:0]              cmd_s2;
    logic [2:0]              ba_s1;
    logic [2:0]              ba_s2;
    logic [`MR_WIDTH-1:0]    addr_s1;
    logic [`MR_WIDTH-1:0]    addr_s2;
    logic                    odt_s1;
    logic                    odt_s2;
    logic                    hot_s1;
    logic                    hot_s2;
    logic [`MR_WIDTH-1:0]    mr2;
    logic [`MR_WIDTH-1:0]    mr3;
    logic [`LAT_W-1:0]       wl;
    logic [`LAT_W-1:0]       rl;
    logic                    start_rd;
    logic                    start_wr;
    logic                    chop_rd;
    logic                    chop_wr;
    logic                    nibble_hi;
    logic                    rd_req;
    logic                    wr_req;
    logic                    autopre;
    logic                    sr_double;
    term_mode_t              term;
    logic [2:0]              term_code;
    logic [7:0]              dq;
    logic                    dq_oe_n;
  } top_regs_t;

endpackage

// >>> core/burst_if.sv
// Carries one burst request and its progress between the mode logic and a sequencer.
// Assumes both ends run on ref_clk.
`timescale 1ns/1ps
`default_nettype none
`include "mode_regs_consts.svh"

interface burst_if;
  import mode_regs_pkg::*;
  logic                start;
  logic [`LAT_W-1:0]   latency;
  logic                chop;
  logic                ck_rise;
  logic                ck_fall;
  logic                active;
  logic [3:0]          beat;

  modport ctrl (output start, output latency, output chop, output ck_rise,
                output ck_fall, input active, input beat);
  modport seq  (input start, input latency, input chop, input ck_rise,
                input ck_fall, output active, output beat);
endinterface

`default_nettype wire

// >>> core/burst_sequencer.sv
// Waits a latency in DRAM clock cycles, then steps through one burst, a beat per edge.
// Assumes the edge strobes come from a synchronised DRAM clock on ref_clk.
`timescale 1ns/1ps
`default_nettype none
`include "mode_regs_consts.svh"

module burst_sequencer
  import mode_regs_pkg::*;
(
  input  wire logic  ref_clk,
  input  wire logic  resetn,
  burst_if.seq       bus
);

  seq_regs_t r_reg;
  seq_regs_t r_next;

  // A new start restarts the sequence; a start during the previous wait or burst drops what is left of it.
  always_comb begin
    r_next = r_reg;
    unique case (r_reg.state)
      SEQ_IDLE: begin
      end
      SEQ_WAIT: begin
        if (bus.ck_rise) begin
          if (r_next.cnt <= `LAT_W'(1)) begin
            r_next.state = SEQ_BURST;
            r_next.beat  = 4'h0;
          end else begin
            r_next.cnt = r_reg.cnt - `LAT_W'(1);
          end
        end
      end
      SEQ_BURST: begin
        if (bus.ck_rise || bus.ck_fall) begin
          if (r_reg.beat == r_reg.last) begin
            r_next.state = SEQ_IDLE;
          end else begin
            r_next.beat = r_reg.beat + 4'h1;
          end
        end
      end
      default: r_next.state = SEQ_IDLE;
    endcase
    if (bus.start) begin
      r_next.state = SEQ_WAIT;
      r_next.cnt   = bus.latency;
      r_next.beat  = 4'h0;
      r_next.last  = bus.chop ? (`BURST_CHOP_BEATS - 4'h1) : (`BURST_FULL_BEATS - 4'h1);
    end
  end

  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      r_reg <= '{state: SEQ_IDLE, cnt: '0, beat: 4'h0, last: 4'h0};
    end else begin
      r_reg <= r_next;
    end
  end

  assign bus.active = (r_reg.state == SEQ_BURST);
  assign bus.beat   = r_reg.beat;

endmodule // burst_sequencer

`default_nettype wire

// >>> core/mode_regs_two_three.sv
// Mode registers two and three of the DRAM: write latency, self-refresh rate,
// write-time termination and calibration readout.
// Assumes the DRAM clock and command pins are asynchronous to ref_clk and far slower.
`timescale 1ns/1ps
`default_nettype none
`include "mode_regs_consts.svh"

////////////////////////////////////////////////////////////////////////////////
// Operation
// - Mode register set to register two stores it until rewritten or reset.
// - Register two bits 5 to 3 hold the write CAS latency.
// - Total write latency is write CAS latency plus posted additive latency.
// - Register two bit 6 doubles self-refresh rate when the case runs hot.
// - With both rate bits clear, self-refresh runs at single rate.
// - Register two bit 7 forces double self-refresh rate always.
// - Register two bits 10 and 9 select write termination; nonzero enables it.
// - Write termination replaces nominal during each write burst, then restores.
// - Nominal and write termination are independent; nominal off means high impedance.
// - No write termination while write leveling is active.
// - Register three bit 2 redirects reads to calibration data chosen by bits 1:0.
// - Selector 00 picks the fixed pattern; selector ignored when readout off.
// - In readout mode every read is redirected, repeatable without limit.
// - Reset acts normally even during calibration readout.
// - Bank address 010 selects register two, 011 register three.
// - Pattern alternates from zero: eight beats full burst, four when chopped.
module mode_regs_two_three
  import mode_regs_pkg::*;
#(
  parameter logic [31:0] CWL_TABLE = `CWL_TABLE_DEFAULT
)
(
  input  wire logic                    ref_clk,
  input  wire logic                    resetn,
  input  wire logic                    ck_pin,
  input  wire logic                    cs_n_pin,
  input  wire logic                    ras_n_pin,
  input  wire logic                    cas_n_pin,
  input  wire logic                    we_n_pin,
  input  wire logic [2:0]              ba_pin,
  input  wire logic [`MR_WIDTH-1:0]    addr_pin,
  input  wire logic                    odt_pin,
  input  wire logic                    case_hot_pin,
  input  wire logic [`LAT_W-1:0]       posted_additive_latency,
  input  wire logic [`LAT_W-1:0]       read_cas_latency,
  input  wire logic [2:0]              nominal_termination_code,
  input  wire logic                    write_leveling_en,
  input  wire logic                    self_refresh_active,
  output logic [`MR_WIDTH-1:0]         mode_reg_two,
  output logic [`MR_WIDTH-1:0]         mode_reg_three,
  output logic [`LAT_W-1:0]            total_write_latency,
  output logic                         selfrefresh_rate_double,
  output term_mode_t                   term_mode,
  output logic [2:0]                   term_value_code,
  output logic                         calibration_readout_en,
  output logic                         array_read_req,
  output logic                         array_write_req,
  output logic                         array_autoprecharge,
  output logic [7:0]                   dq_out,
  output logic                         dq_oe_n
);

  ////////////////////////////////////////////////////////////////////////////////
  // Burst sequencers for read data and for write termination timing.

  burst_if rd_bus ();
  burst_if wr_bus ();

  top_regs_t r_reg;
  top_regs_t r_next;

  logic ck_rise;
  logic ck_fall;

  // Edges are taken between the second and third flops, never from the first.
  assign ck_rise = r_reg.ck_s2 & ~r_reg.ck_s3;
  assign ck_fall = ~r_reg.ck_s2 & r_reg.ck_s3;

  assign rd_bus.start   = r_reg.start_rd;
  assign rd_bus.latency = r_reg.rl;
  assign rd_bus.chop    = r_reg.chop_rd;
  assign rd_bus.ck_rise = ck_rise;
  assign rd_bus.ck_fall = ck_fall;
  assign wr_bus.start   = r_reg.start_wr;
  assign wr_bus.latency = r_reg.wl;
  assign wr_bus.chop    = r_reg.chop_wr;
  assign wr_bus.ck_rise = ck_rise;
  assign wr_bus.ck_fall = ck_fall;

  burst_sequencer u_read_seq (
    .ref_clk (ref_clk),
    .resetn  (resetn),
    .bus     (rd_bus.seq)
  );

  burst_sequencer u_write_seq (
    .ref_clk (ref_clk),
    .resetn  (resetn),
    .bus     (wr_bus.seq)
  );

  ////////////////////////////////////////////////////////////////////////////////
  // Field views of the stored registers.

  logic [2:0] cwl_code;
  logic       auto_selfrefresh_rate;
  logic       forced_selfrefresh_rate;
  logic [1:0] write_time_termination;
  logic       cal_en;
  logic [1:0] cal_sel;
  logic [3:0] cwl_cycles;
  logic       is_mode_set;
  logic       is_read;
  logic       is_write;
  logic       write_term_on;
  logic       nominal_term_on;
  logic [7:0] cal_pattern;
  logic [2:0] pat_idx;

  assign cwl_code                = r_reg.mr2[`MR2_CWL_MSB:`MR2_CWL_LSB];
  assign auto_selfrefresh_rate   = r_reg.mr2[`MR2_AUTO_SR_BIT];
  assign forced_selfrefresh_rate = r_reg.mr2[`MR2_FORCED_SR_BIT];
  assign write_time_termination  = r_reg.mr2[`MR2_WRTERM_MSB:`MR2_WRTERM_LSB];
  assign cal_en                  = r_reg.mr3[`MR3_CAL_EN_BIT];
  assign cal_sel                 = r_reg.mr3[`MR3_CAL_SEL_MSB:`MR3_CAL_SEL_LSB];

  // Held in a net, since a literal cannot be indexed.
  assign cal_pattern = `CAL_PATTERN;
  assign pat_idx     = 3'(rd_bus.beat) +
                       (r_reg.nibble_hi ? `NIBBLE_OFFSET : 3'h0);

  assign write_term_on   = wr_bus.active && (write_time_termination != 2'h0) &&
                           !write_leveling_en;
  assign nominal_term_on = r_reg.odt_s2 && (nominal_termination_code != 3'h0) &&
                           !rd_bus.active;

  // The code-to-cycles map is a parameter because the encoding varies by speed grade.
  assign cwl_cycles = CWL_TABLE[{cwl_code, 2'b00} +: 4];

  // Command pins packed as {cs_n, ras_n, cas_n, we_n}.
  assign is_mode_set = ck_rise && (r_reg.cmd_s2 == 4'h0);
  assign is_read     = ck_rise && (r_reg.cmd_s2 == 4'h5);
  assign is_write    = ck_rise && (r_reg.cmd_s2 == 4'h4);

  ////////////////////////////////////////////////////////////////////////////////
  // Next-state logic.

  always_comb begin
    r_next = r_reg;

    r_next.ck_s1   = ck_pin;
    r_next.ck_s2   = r_reg.ck_s1;
    r_next.ck_s3   = r_reg.ck_s2;
    r_next.cmd_s1  = {cs_n_pin, ras_n_pin, cas_n_pin, we_n_pin};
    r_next.cmd_s2  = r_reg.cmd_s1;
    r_next.ba_s1   = ba_pin;
    r_next.ba_s2   = r_reg.ba_s1;
    r_next.addr_s1 = addr_pin;
    r_next.addr_s2 = r_reg.addr_s1;
    r_next.odt_s1  = odt_pin;
    r_next.odt_s2  = r_reg.odt_s1;
    r_next.hot_s1  = case_hot_pin;
    r_next.hot_s2  = r_reg.hot_s1;

    r_next.start_rd = 1'b0;
    r_next.start_wr = 1'b0;
    r_next.rd_req   = 1'b0;
    r_next.wr_req   = 1'b0;

    // Reserved bits are stored as written; keeping them zero is the controller's part.
    if (is_mode_set) begin
      if (r_reg.ba_s2 == `BA_MODE_TWO) begin
        r_next.mr2 = r_reg.addr_s2;
      end else if (r_reg.ba_s2 == `BA_MODE_THREE) begin
        r_next.mr3 = r_reg.addr_s2;
      end
    end

    r_next.wl = `LAT_W'(posted_additive_latency + {1'b0, cwl_cycles});
    r_next.rl = `LAT_W'(posted_additive_latency + read_cas_latency);

    // Low on the burst length bit selects a chopped burst of four beats.
    if (is_read) begin
      if (cal_en) begin
        r_next.start_rd  = 1'b1;
        r_next.chop_rd   = ~r_reg.addr_s2[`ADDR_BURST_LEN_BIT];
        r_next.nibble_hi = r_reg.addr_s2[`ADDR_NIBBLE_BIT];
      end else begin
        r_next.rd_req  = 1'b1;
        r_next.autopre = r_reg.addr_s2[`ADDR_AUTOPRE_BIT];
      end
    end

    // Writes during readout mode are not passed to the array.
    if (is_write) begin
      r_next.start_wr = 1'b1;
      r_next.chop_wr  = ~r_reg.addr_s2[`ADDR_BURST_LEN_BIT];
      r_next.wr_req   = ~cal_en;
      r_next.autopre  = r_reg.addr_s2[`ADDR_AUTOPRE_BIT];
    end

    // The hot input trips early, so the automatic rate may rise a little below 85 degrees.
    r_next.sr_double = self_refresh_active &&
                       (forced_selfrefresh_rate ||
                        (auto_selfrefresh_rate && r_reg.hot_s2));

    if (write_term_on) begin
      r_next.term      = TERM_WRITE;
      r_next.term_code = {1'b0, write_time_termination};
    end else if (nominal_term_on) begin
      r_next.term      = TERM_NOMINAL;
      r_next.term_code = nominal_termination_code;
    end else begin
      r_next.term      = TERM_OFF;
      r_next.term_code = 3'h0;
    end

    // Reserved selector values drive zeros rather than stale data.
    if (rd_bus.active) begin
      r_next.dq_oe_n = 1'b0;
      if (cal_sel == `CAL_SEL_PATTERN) begin
        r_next.dq = {8{cal_pattern[pat_idx]}};
      end else begin
        r_next.dq = 8'h00;
      end
    end else begin
      r_next.dq_oe_n = 1'b1;
      r_next.dq      = 8'h00;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // State register; reset clears readout mode like everything else.

  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      r_reg <= '{
        ck_s1: 1'b0,
        ck_s2: 1'b0,
        ck_s3: 1'b0,
        cmd_s1: 4'hF,
        cmd_s2: 4'hF,
        ba_s1: 3'h0,
        ba_s2: 3'h0,
        addr_s1: '0,
        addr_s2: '0,
        odt_s1: 1'b0,
        odt_s2: 1'b0,
        hot_s1: 1'b0,
        hot_s2: 1'b0,
        mr2: `MR2_RESET,
        mr3: `MR3_RESET,
        wl: '0,
        rl: '0,
        start_rd: 1'b0,
        start_wr: 1'b0,
        chop_rd: 1'b0,
        chop_wr: 1'b0,
        nibble_hi: 1'b0,
        rd_req: 1'b0,
        wr_req: 1'b0,
        autopre: 1'b0,
        sr_double: 1'b0,
        term: TERM_OFF,
        term_code: 3'h0,
        dq: 8'h00,
        dq_oe_n: 1'b1
      };
    end else begin
      r_reg <= r_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Outputs, all straight from the state register.

  assign mode_reg_two            = r_reg.mr2;
  assign mode_reg_three          = r_reg.mr3;
  assign total_write_latency     = r_reg.wl;
  assign selfrefresh_rate_double = r_reg.sr_double;
  assign term_mode               = r_reg.term;
  assign term_value_code         = r_reg.term_code;
  assign calibration_readout_en  = r_reg.mr3[`MR3_CAL_EN_BIT];
  assign array_read_req          = r_reg.rd_req;
  assign array_write_req         = r_reg.wr_req;
  assign array_autoprecharge     = r_reg.autopre;
  assign dq_out                  = r_reg.dq;
  assign dq_oe_n                 = r_reg.dq_oe_n;

endmodule // mode_regs_two_three

`default_nettype wire

// >>> tb/mode_regs_two_three_monitor.sv
// Port assertions for the mode register two and three block.
// Assumes binding onto mode_regs_two_three, which hands on its latency table.
`timescale 1ns/1ps
`default_nettype none
`include "mode_regs_consts.svh"
module mode_regs_two_three_monitor
  import mode_regs_pkg::*;
#(
  parameter logic [31:0] CWL_TABLE = `CWL_TABLE_DEFAULT
)
(
  input wire logic        ref_clk,
  input wire logic        resetn,
  input wire logic        cs_n_pin,
  input wire logic        case_hot_pin,
  input wire logic [4:0]  posted_additive_latency,
  input wire logic        write_leveling_en,
  input wire logic        self_refresh_active,
  input wire logic [17:0] mode_reg_two,
  input wire logic [17:0] mode_reg_three,
  input wire logic [4:0]  total_write_latency,
  input wire logic        selfrefresh_rate_double,
  input wire term_mode_t  term_mode,
  input wire logic [2:0]  term_value_code,
  input wire logic        calibration_readout_en,
  input wire logic        array_read_req,
  input wire logic [7:0]  dq_out,
  input wire logic        dq_oe_n
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!resetn);
  logic [4:0] wl_exp;
  assign wl_exp = posted_additive_latency + {1'b0, CWL_TABLE[4*mode_reg_two[5:3] +: 4]};
  ////////////////////////////////////////////////////////////////////////////////
  property p_reset_clear;
    $rose(resetn) |-> mode_reg_two == '0 && mode_reg_three == '0;
  endproperty
  a_reset_clear: assert property (p_reset_clear) else $error("registers not clear");
  // Eight quiet cycles outlast the pin synchroniser, so no command can still be in flight.
  property p_hold; cs_n_pin [*8] |=> $stable(mode_reg_two) && $stable(mode_reg_three); endproperty
  a_hold: assert property (p_hold) else $error("mode register changed without a command");
  property p_wl_sum;
    ($stable(mode_reg_two) && $stable(posted_additive_latency)) [*4] |-> total_write_latency == wl_exp;
  endproperty
  a_wl_sum: assert property (p_wl_sum) else $error("write latency wrong");
  property p_sr_forced; (self_refresh_active && mode_reg_two[7]) [*3] |-> selfrefresh_rate_double;
  endproperty
  a_sr_forced: assert property (p_sr_forced) else $error("forced rate not doubled");
  property p_sr_auto;
    (self_refresh_active && mode_reg_two[7:6] == 2'b01 && $stable(case_hot_pin)) [*6]
      |-> selfrefresh_rate_double == case_hot_pin;
  endproperty
  a_sr_auto: assert property (p_sr_auto) else $error("auto rate wrong");
  property p_no_wrterm_lvl; write_leveling_en && $past(write_leveling_en) |-> term_mode != TERM_WRITE;
  endproperty
  a_no_wrterm_lvl: assert property (p_no_wrterm_lvl) else $error("write term in leveling");
  property p_wrterm_val;
    term_mode == TERM_WRITE |-> mode_reg_two[10:9] != 2'b00 && term_value_code == {1'b0, mode_reg_two[10:9]};
  endproperty
  a_wrterm_val: assert property (p_wrterm_val) else $error("write term value wrong");
  property p_cal_rd; mode_reg_three[2] && $past(mode_reg_three[2]) |-> !array_read_req; endproperty
  a_cal_rd: assert property (p_cal_rd) else $error("array read in readout");
  property p_dq_pat; !dq_oe_n |-> dq_out inside {8'h00, 8'hFF} && calibration_readout_en; endproperty
  a_dq_pat: assert property (p_dq_pat) else $error("bad readout data");
  c_wrterm: cover property (term_mode == TERM_WRITE);
  c_burst: cover property ($fell(dq_oe_n));
  c_sr: cover property (selfrefresh_rate_double);
endmodule // mode_regs_two_three_monitor
bind mode_regs_two_three mode_regs_two_three_monitor #(.CWL_TABLE(CWL_TABLE)) u_mon (
  .ref_clk, .resetn, .cs_n_pin, .case_hot_pin, .posted_additive_latency, .write_leveling_en,
  .self_refresh_active, .mode_reg_two, .mode_reg_three, .total_write_latency,
  .selfrefresh_rate_double, .term_mode, .term_value_code, .calibration_readout_en,
  .array_read_req, .dq_out, .dq_oe_n);
`default_nettype wire

// >>> tb/mem_ctrl_model.sv
// Controller model that drives the command pins for one DRAM clock cycle per request.
// Assumes the bench holds req until ack rises and that ck runs free.
`timescale 1ns/1ps
`default_nettype none
module mem_ctrl_model (
  input  wire logic        ck,
  input  wire logic        req,
  input  wire logic        slow,
  input  wire logic [2:0]  cmd,
  input  wire logic [2:0]  ba,
  input  wire logic [17:0] addr,
  output var logic         ack,
  output var logic         cs_n_pin,
  output var logic         ras_n_pin,
  output var logic         cas_n_pin,
  output var logic         we_n_pin,
  output var logic [2:0]   ba_pin,
  output var logic [17:0]  addr_pin
);
  logic odd = 1'b0;
  initial begin
    ack = 1'b0;
    {cs_n_pin, ras_n_pin, cas_n_pin, we_n_pin} = 4'hF;
    ba_pin = 3'h0;
    addr_pin = 18'h00000;
  end
  // Pins move on the falling edge so they are steady across the rise.
  always @(negedge ck) begin
    odd <= !odd;
    if (req && !ack && (!slow || odd)) begin
      {cs_n_pin, ras_n_pin, cas_n_pin, we_n_pin} <= {1'b0, cmd};
      ba_pin <= ba;
      addr_pin <= addr;
      ack <= 1'b1;
    end else begin
      // Bank and address lines toggle while deselected so a stale value never looks valid.
      {cs_n_pin, ras_n_pin, cas_n_pin, we_n_pin} <= 4'hF;
      ba_pin <= ~ba_pin;
      addr_pin <= ~addr_pin;
      ack <= 1'b0;
    end
  end
endmodule // mem_ctrl_model
`default_nettype wire

// >>> tb/test_sdram_mode_regs_two_three.sv
// Bench for the mode register two and three block with a controller model on its pins.
// Assumes the package, design, monitor and controller model are compiled before it.
`timescale 1ns/1ps
`default_nettype none
module test_sdram_mode_regs_two_three;
  import mode_regs_pkg::*;
  localparam logic [31:0] TBL = 32'h4F2A6B93;
  localparam logic [2:0]  MODE_REGISTER_SET_CMD = 3'h0;
  localparam logic [2:0]  RD  = 3'h5;
  localparam logic [2:0]  WR  = 3'h4;
  logic        ref_clk = 1'b0, resetn = 1'b0, ck_pin = 1'b0, req = 1'b0, slow = 1'b0;
  logic        odt_pin = 1'b0, case_hot_pin = 1'b0, write_leveling_en = 1'b0;
  logic        self_refresh_active = 1'b0;
  logic [2:0]  cmd = 3'h0, ba = 3'h0, nominal_termination_code = 3'h0;
  logic [17:0] addr = 18'h00000;
  logic [4:0]  posted_additive_latency = 5'h00, read_cas_latency = 5'h03;
  logic        ack, cs_n_pin, ras_n_pin, cas_n_pin, we_n_pin, dq_oe_n;
  logic [2:0]  ba_pin, term_value_code;
  logic [17:0] addr_pin, mode_reg_two, mode_reg_three;
  logic [4:0]  total_write_latency;
  logic        selfrefresh_rate_double, calibration_readout_en;
  logic        array_read_req, array_write_req, array_autoprecharge;
  term_mode_t  term_mode;
  logic [7:0]  dq_out;
  int          seed = 32'hF041, fail_count = 0, samples_checked = 0, rd_n = 0, wr_n = 0;

  always #2 ref_clk = ~ref_clk;
  initial begin
    #1.3;
    forever #80 ck_pin = ~ck_pin;
  end
  always @(posedge ref_clk) begin
    rd_n += array_read_req;
    wr_n += array_write_req;
  end
  mode_regs_two_three #(.CWL_TABLE(TBL)) DUT (
    .ref_clk, .resetn, .ck_pin, .cs_n_pin, .ras_n_pin, .cas_n_pin, .we_n_pin, .ba_pin,
    .addr_pin, .odt_pin, .case_hot_pin, .posted_additive_latency, .read_cas_latency,
    .nominal_termination_code, .write_leveling_en, .self_refresh_active, .mode_reg_two,
    .mode_reg_three, .total_write_latency, .selfrefresh_rate_double, .term_mode,
    .term_value_code, .calibration_readout_en, .array_read_req, .array_write_req,
    .array_autoprecharge, .dq_out, .dq_oe_n);
  mem_ctrl_model u_ctrl (
    .ck(ck_pin), .req, .slow, .cmd, .ba, .addr, .ack, .cs_n_pin, .ras_n_pin, .cas_n_pin,
    .we_n_pin, .ba_pin, .addr_pin);
  ////////////////////////////////////////////////////////////////////////////////
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", samples_checked, fail_count);
    if (fail_count == 0 && samples_checked > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  task automatic check(input string what, input logic [35:0] exp, input logic [35:0] got);
    samples_checked++;
    if (got !== exp) begin
      fail_count++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask
  function automatic logic [4:0] wl_of(input logic [4:0] al, input logic [2:0] c);
    return al + {1'b0, TBL[4*c +: 4]};
  endfunction
  // Reserved bits other than 16 and 15 stay zero and at most one rate bit is set.
  function automatic logic [17:0] mr2_rand(input logic [2:0] c);
    logic [17:0] v;
    v = 18'($random(seed)) & 18'h186F8;
    if (v[7]) v[6] = 1'b0;
    v[5:3] = c;
    return v;
  endfunction
  task automatic issue(input logic [2:0] c, input logic [2:0] b, input logic [17:0] a);
    int n;
    cmd = c;
    ba = b;
    addr = a;
    slow = 1'($random(seed));
    req = 1'b1;
    for (n = 0; ack !== 1'b1 && n < 400; n++) @(negedge ref_clk);
    req = 1'b0;
    if (n >= 400) n = 800;
    for (n = n; ack !== 1'b0 && n < 800; n++) @(negedge ref_clk);
    if (n >= 800) begin
      fail_count++;
      end_of_test();
    end
    repeat (4) @(negedge ref_clk);
  endtask
  task automatic wait_oe();
    int n;
    for (n = 0; dq_oe_n !== 1'b0 && n < 2000; n++) @(negedge ref_clk);
    if (n >= 2000) begin
      fail_count++;
      end_of_test();
    end
  endtask
  // Samples each beat near its middle, one ck edge apart.
  task automatic read_burst(input logic chop, input logic nib);
    int k;
    issue(RD, 3'h0, {5'h0, !chop, 9'h0, nib, 2'h0});
    wait_oe();
    repeat (10) @(negedge ref_clk);
    for (k = 0; dq_oe_n === 1'b0 && k < 12; k++) begin
      check("beat", k[0] ? 8'hFF : 8'h00, dq_out);
      repeat (20) @(negedge ref_clk);
    end
    check("beats", chop ? 4 : 8, k);
  endtask
  task automatic write_term(input logic lev, input logic [2:0] nom, input logic en);
    int n, seen, w;
    write_leveling_en = lev;
    nominal_termination_code = nom;
    odt_pin = 1'b1;
    repeat (8) @(negedge ref_clk);
    check("term idle", nom != 0 ? TERM_NOMINAL : TERM_OFF, term_mode);
    w = wr_n;
    issue(WR, 3'h0, 18'h01000);
    seen = 0;
    for (n = 0; n < 1600; n++) begin
      @(negedge ref_clk);
      seen += (term_mode === TERM_WRITE);
    end
    check("write req", w + 1, wr_n);
    check("term write", en, seen > 140 && seen < 180);
    check("term back", nom != 0 ? TERM_NOMINAL : TERM_OFF, term_mode);
    odt_pin = 1'b0;
    repeat (8) @(negedge ref_clk);
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    int c, k;
    logic [17:0] v;
    repeat (10) @(negedge ref_clk);
    check("reset two", 0, mode_reg_two);
    check("reset three", 0, mode_reg_three);
    check("reset term", TERM_OFF, term_mode);
    resetn = 1'b1;
    repeat (4) @(negedge ref_clk);
    for (c = 0; c < 8; c++) begin
      posted_additive_latency = 5'($random(seed)) & 5'h0F;
      v = mr2_rand(c[2:0]);
      issue(MODE_REGISTER_SET_CMD, 3'h2, v);
      check("mode two", v, mode_reg_two);
      check("wl", wl_of(posted_additive_latency, c[2:0]), total_write_latency);
    end
    for (c = 0; c < 8; c++) begin
      if (c != 2 && c != 3) begin
        issue(MODE_REGISTER_SET_CMD, c[2:0], ~v);
        check("ignored ba", {v, 18'h0}, {mode_reg_two, mode_reg_three});
      end
    end
    $display("test mode set done");
    for (k = 0; k < 6; k++) begin
      issue(MODE_REGISTER_SET_CMD, 3'h2, {10'h0, k[2:1], 6'h0});
      self_refresh_active = 1'b1;
      case_hot_pin = k[0];
      repeat (8) @(negedge ref_clk);
      check("sr double", k[2] || (k[1] && k[0]), selfrefresh_rate_double);
      self_refresh_active = 1'b0;
    end
    $display("test self refresh done");
    for (k = 0; k < 4; k++) begin
      issue(MODE_REGISTER_SET_CMD, 3'h2, 18'(k) << 9);
      write_term(1'b0, 3'(k), k != 0);
    end
    write_term(1'b1, 3'h1, 1'b0);
    $display("test write term done");
    issue(MODE_REGISTER_SET_CMD, 3'h3, {16'h0, 2'($random(seed))});
    check("cal off", 0, calibration_readout_en);
    k = rd_n;
    issue(RD, 3'h0, 18'h00400);
    check("array read", k + 1, rd_n);
    check("autopre", 1, array_autoprecharge);
    repeat (1200) @(negedge ref_clk);
    issue(MODE_REGISTER_SET_CMD, 3'h3, 18'h00004);
    check("cal on", 1, calibration_readout_en);
    k = rd_n;
    read_burst(1'b0, 1'b0);
    read_burst(1'b1, 1'b1);
    read_burst(1'b1, 1'b0);
    check("no array read", k, rd_n);
    $display("test readout done");
    issue(RD, 3'h0, 18'h01000);
    wait_oe();
    resetn = 1'b0;
    @(negedge ref_clk);
    check("reset cal", {18'h0, 1'b1}, {mode_reg_three, dq_oe_n});
    resetn = 1'b1;
    repeat (4) @(negedge ref_clk);
    k = rd_n;
    issue(RD, 3'h0, 18'h00000);
    check("read after reset", k + 1, rd_n);
    $display("test reset in readout done");
    end_of_test();
  end
endmodule // test_sdram_mode_regs_two_three
`default_nettype wire
